// File: verilog/fsc_codec.sv
// Four-wire ternary symbol codec: 3-bit groups to four-level wire patterns and back.
// Assumes an external analog driver/slicer converts level codes to and from wire voltages.
`timescale 1ns/1ps
module fsc_codec (
   input  wire logic                                clk,
   input  wire logic                                sys_rst,
   input  wire logic [fsc_pkg::BITS_PER_SYM-1:0]    tx_bits,
   input  wire logic                                tx_valid,
   output logic [4*fsc_pkg::LEVEL_W-1:0]            serial_out_lanes,
   output logic                                     tx_out_valid,
   input  wire logic [4*fsc_pkg::LEVEL_W-1:0]       serial_in_lanes,
   input  wire logic                                rx_in_valid,
   output logic [fsc_pkg::BITS_PER_SYM-1:0]         rx_bits,
   output logic                                     rx_valid,
   output logic                                     rx_tie
);
   import fsc_pkg::*;

   // Elaboration check: the slicer sums need the level codes to fit the package widths
   if (LEVEL_W != 3 || NUM_WIRES != 4 || BITS_PER_SYM != 3) begin : g_bad_width
      $error("fsc_codec supports only 3-bit levels on four wires");
   end

   // The rate window is only a link property; the logic takes one symbol per clk at any rate
   if (SYM_RATE_MIN_CGSPS > SYM_RATE_MAX_CGSPS) begin : g_bad_rate
      $error("fsc_codec symbol rate window is reversed");
   end

   // Map one 3-bit group to (wire_three, wire_two, wire_one, wire_zero)
   function automatic logic [4*LEVEL_W-1:0] fsc_encode(input logic [2:0] grp);
      logic [4*LEVEL_W-1:0] pat;
      case (grp)
         3'h0: pat = {LVL_NEG_ONE,   LVL_POS_THIRD, LVL_POS_THIRD, LVL_POS_THIRD};
         3'h1: pat = {LVL_NEG_THIRD, LVL_POS_ONE,   LVL_NEG_THIRD, LVL_NEG_THIRD};
         3'h2: pat = {LVL_NEG_THIRD, LVL_NEG_THIRD, LVL_POS_ONE,   LVL_NEG_THIRD};
         3'h3: pat = {LVL_POS_THIRD, LVL_POS_THIRD, LVL_POS_THIRD, LVL_NEG_ONE};
         3'h4: pat = {LVL_NEG_THIRD, LVL_NEG_THIRD, LVL_NEG_THIRD, LVL_POS_ONE};
         3'h5: pat = {LVL_POS_THIRD, LVL_POS_THIRD, LVL_NEG_ONE,   LVL_POS_THIRD};
         3'h6: pat = {LVL_POS_THIRD, LVL_NEG_ONE,   LVL_POS_THIRD, LVL_POS_THIRD};
         3'h7: pat = {LVL_POS_ONE,   LVL_NEG_THIRD, LVL_NEG_THIRD, LVL_NEG_THIRD};
         default: pat = {LVL_POS_ONE, LVL_NEG_THIRD, LVL_NEG_THIRD, LVL_NEG_THIRD};
      endcase
      return pat;
   endfunction : fsc_encode

   // True when a lane holds one of the four legal level codes
   function automatic logic fsc_lvl_ok(input logic [LEVEL_W-1:0] lvl);
      return (lvl == LVL_POS_ONE) || (lvl == LVL_POS_THIRD) ||
             (lvl == LVL_NEG_THIRD) || (lvl == LVL_NEG_ONE);
   endfunction : fsc_lvl_ok

   // ---------------- Transmit path ----------------
   logic [4*LEVEL_W-1:0] tx_lanes_reg;
   logic [4*LEVEL_W-1:0] tx_lanes_next;
   logic                 tx_vld_reg;
   logic                 tx_vld_next;

   // Idle symbols repeat the last pattern so common_level never steps between frames
   always_comb begin
      tx_lanes_next = tx_lanes_reg;
      tx_vld_next   = tx_valid;
      if (tx_valid) begin
         tx_lanes_next = fsc_encode(tx_bits);
      end
   end

   // Reset pattern is the 000 symbol, itself balanced
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_lanes_reg <= {LVL_NEG_ONE, LVL_POS_THIRD, LVL_POS_THIRD, LVL_POS_THIRD};
         tx_vld_reg   <= 1'b0;
      end else begin
         tx_lanes_reg <= tx_lanes_next;
         tx_vld_reg   <= tx_vld_next;
      end
   end

   // Outgoing lanes only; no path feeds back from the receive side
   assign serial_out_lanes = tx_lanes_reg;
   assign tx_out_valid     = tx_vld_reg;

   // ---------------- Receive path ----------------
   logic [2:0] slc_above;
   logic [2:0] slc_tie;

   // Three comparators, one per subchannel
   fsc_slicer #(.WEIGHTS(WGT_DECODE_ZERO)) u_slc_zero (
      .lanes (serial_in_lanes),
      .above (slc_above[0]),
      .tie   (slc_tie[0])
   );
   fsc_slicer #(.WEIGHTS(WGT_DECODE_ONE)) u_slc_one (
      .lanes (serial_in_lanes),
      .above (slc_above[1]),
      .tie   (slc_tie[1])
   );
   fsc_slicer #(.WEIGHTS(WGT_DECODE_TWO)) u_slc_two (
      .lanes (serial_in_lanes),
      .above (slc_above[2]),
      .tie   (slc_tie[2])
   );

   logic [2:0] rx_bits_reg;
   logic [2:0] rx_bits_next;
   logic       rx_vld_reg;
   logic       rx_vld_next;
   logic       rx_tie_reg;
   logic       rx_tie_next;

   // A zero sum is undecidable; the bit keeps its last value rather than guess
   always_comb begin
      rx_bits_next = rx_bits_reg;
      rx_tie_next  = rx_tie_reg;
      rx_vld_next  = rx_in_valid;
      if (rx_in_valid) begin
         rx_tie_next = |slc_tie;
         for (int i = 0; i < BITS_PER_SYM; i++) begin
            if (!slc_tie[i]) begin
               rx_bits_next[i] = slc_above[i];
            end
         end
      end
   end

   // Receive registers run beside the transmit ones, so both directions work at once
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_bits_reg <= 3'h0;
         rx_vld_reg  <= 1'b0;
         rx_tie_reg  <= 1'b0;
      end else begin
         rx_bits_reg <= rx_bits_next;
         rx_vld_reg  <= rx_vld_next;
         rx_tie_reg  <= rx_tie_next;
      end
   end

   assign rx_bits  = rx_bits_reg;
   assign rx_valid = rx_vld_reg;
   assign rx_tie   = rx_tie_reg;

   // ---------------- Checks ----------------
   logic signed [SUM_W-1:0] out_cm_sum;
   logic signed [SUM_W-1:0] in_sum_zero;
   logic signed [SUM_W-1:0] in_sum_one;
   logic signed [SUM_W-1:0] in_sum_two;
   logic [2:0]              in_sign;
   logic                    in_any_tie;
   logic [2:0]              out_decoded;

   // Helper decode of what is driven and received, used for round-trip, balance and receive checks
   always_comb begin
      out_cm_sum  = fsc_wsum(4'hf, serial_out_lanes);
      in_sum_zero = fsc_wsum(WGT_DECODE_ZERO, serial_in_lanes);
      in_sum_one  = fsc_wsum(WGT_DECODE_ONE, serial_in_lanes);
      in_sum_two  = fsc_wsum(WGT_DECODE_TWO, serial_in_lanes);
      // Signs kept as plain signals so the checks can look back at them
      in_sign     = {in_sum_two > 0, in_sum_one > 0, in_sum_zero > 0};
      in_any_tie  = (in_sum_zero == 0) || (in_sum_one == 0) || (in_sum_two == 0);
      out_decoded = {fsc_wsum(WGT_DECODE_TWO, serial_out_lanes) > 0,
                     fsc_wsum(WGT_DECODE_ONE, serial_out_lanes) > 0,
                     fsc_wsum(WGT_DECODE_ZERO, serial_out_lanes) > 0};
   end

   chk_cm_balanced: assert property (@(posedge clk) disable iff (sys_rst)
      out_cm_sum == 0) else $error("Transmit pattern shifts common level");

   chk_levels_legal: assert property (@(posedge clk) disable iff (sys_rst)
      fsc_lvl_ok(serial_out_lanes[0 +: 3]) && fsc_lvl_ok(serial_out_lanes[3 +: 3]) &&
      fsc_lvl_ok(serial_out_lanes[6 +: 3]) && fsc_lvl_ok(serial_out_lanes[9 +: 3]))
      else $error("Wire driven to an illegal level");

   chk_code_low: assert property (@(posedge clk) disable iff (sys_rst)
      tx_valid && tx_bits == 3'h1 |=> serial_out_lanes == 12'heff)
      else $error("Group 001 mapped to wrong pattern");

   chk_code_high: assert property (@(posedge clk) disable iff (sys_rst)
      tx_valid && tx_bits == 3'h6 |=> serial_out_lanes == 12'h349)
      else $error("Group 110 mapped to wrong pattern");

   chk_tx_roundtrip: assert property (@(posedge clk) disable iff (sys_rst)
      tx_valid |=> tx_out_valid && out_decoded == $past(tx_bits))
      else $error("Transmitted symbol does not carry the three bits");

   chk_tx_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !tx_valid |=> !tx_out_valid && $stable(serial_out_lanes))
      else $error("Transmit lanes moved without a group");

   chk_rx_sign: assert property (@(posedge clk) disable iff (sys_rst)
      rx_in_valid && in_sum_zero != 0 |=> rx_valid && rx_bits[0] == $past(in_sign[0]))
      else $error("Subchannel zero decoded against its sum sign");

   chk_rx_sign_one: assert property (@(posedge clk) disable iff (sys_rst)
      rx_in_valid && in_sum_one != 0 |=> rx_valid && rx_bits[1] == $past(in_sign[1]))
      else $error("Subchannel one decoded against its sum sign");

   chk_rx_sign_two: assert property (@(posedge clk) disable iff (sys_rst)
      rx_in_valid && in_sum_two != 0 |=> rx_valid && rx_bits[2] == $past(in_sign[2]))
      else $error("Subchannel two decoded against its sum sign");

   // The tie flag must follow the sampled symbol, both set and cleared
   chk_rx_tie_flag: assert property (@(posedge clk) disable iff (sys_rst)
      rx_in_valid |=> rx_tie == $past(in_any_tie))
      else $error("Tie flag does not match the sampled sums");

   chk_rx_tie_hold: assert property (@(posedge clk) disable iff (sys_rst)
      rx_in_valid && in_sum_zero == 0 |=> rx_tie && rx_bits[0] == $past(rx_bits[0]))
      else $error("Zero sum did not hold the bit");

   chk_rx_idle: assert property (@(posedge clk) disable iff (sys_rst)
      !rx_in_valid |=> !rx_valid && $stable(rx_bits))
      else $error("Receive bits moved without a symbol");

endmodule : fsc_codec

// File: verilog/fsc_pkg.sv
// Constants and helpers for the four-wire ternary symbol codec.
// Assumes each wire level travels as a 3-bit two's complement code in thirds of full swing.
package fsc_pkg;

   // Wire level codes, in units of one sixth of peak_swing
   localparam int          LEVEL_W    = 3;
   localparam int          SUM_W      = LEVEL_W + 2;
   localparam int          NUM_WIRES  = 4;
   localparam int          BITS_PER_SYM = 3;
   localparam logic [2:0]  LVL_POS_ONE   = 3'h3;  // +1, +peak_swing/2
   localparam logic [2:0]  LVL_POS_THIRD = 3'h1;  // +1/3, +peak_swing/6
   localparam logic [2:0]  LVL_NEG_THIRD = 3'h7;  // -1/3, -peak_swing/6
   localparam logic [2:0]  LVL_NEG_ONE   = 3'h5;  // -1, -peak_swing/2

   // Comparator weight signs over (wire_three, wire_two, wire_one, wire_zero), 1 = plus
   localparam logic [3:0]  WGT_DECODE_ZERO = 4'hc;  // + + - -
   localparam logic [3:0]  WGT_DECODE_ONE  = 4'ha;  // + - + -
   localparam logic [3:0]  WGT_DECODE_TWO  = 4'h9;  // + - - +

   // Symbol rate window of the link, giga-symbols per second times 100
   localparam int          SYM_RATE_MIN_CGSPS = 3316;
   localparam int          SYM_RATE_MAX_CGSPS = 3750;

   // Fixed latency of each path, in clk cycles
   localparam int          TX_LATENCY = 1;
   localparam int          RX_LATENCY = 1;

   // Weighted sum; the common factor 1/2 is dropped since only the sign matters
   function automatic logic signed [SUM_W-1:0] fsc_wsum(
      input logic [3:0]            mask,
      input logic [4*LEVEL_W-1:0]  lanes
   );
      logic signed [SUM_W-1:0] acc;
      logic signed [SUM_W-1:0] term;
      acc = '0;
      for (int k = 0; k < NUM_WIRES; k++) begin
         term = SUM_W'(signed'(lanes[k*LEVEL_W +: LEVEL_W]));
         acc  = mask[k] ? acc + term : acc - term;
      end
      return acc;
   endfunction : fsc_wsum

endpackage : fsc_pkg

// File: verilog/fsc_slicer.sv
// One zero-threshold comparator over the four received wire levels.
// Assumes lanes are packed wire_zero in the low bits, wire_three in the high bits.
`timescale 1ns/1ps
module fsc_slicer #(
   parameter logic [3:0] WEIGHTS = 4'hc
) (
   input  wire logic [4*fsc_pkg::LEVEL_W-1:0] lanes,
   output logic                               above,
   output logic                               tie
);
   import fsc_pkg::*;

   logic signed [SUM_W-1:0] sum;

   // Sign of the weighted sum; an exact zero is reported so the caller can hold
   always_comb begin
      sum   = fsc_wsum(WEIGHTS, lanes);
      above = (sum > 0);
      tie   = (sum == 0);
   end

endmodule : fsc_slicer

// File: tb/fsc_far_end.sv
// Far-side transceiver model for the codec's quad channels.
// Assumes level codes packed as in fsc_pkg, one symbol per clk.
`timescale 1ns/1ps
module fsc_far_end (
   input  wire logic        clk,
   input  wire logic [11:0] lanes_in,
   input  wire logic        valid_in,
   input  wire logic [11:0] inj_lanes,
   input  wire logic        inj_valid,
   output logic [11:0]      lanes_out,
   output logic             valid_out
);
   logic [11:0] last_reg = 12'h000;

   // Loops each symbol back on the opposite channel, or sends an injected one.
   // Idle lanes show the inverse of the last symbol, so stale levels never decode
   always_comb begin
      valid_out = inj_valid | valid_in;
      lanes_out = inj_valid ? inj_lanes : (valid_in ? lanes_in : ~last_reg);
   end

   // Remember the last symbol sent
   always_ff @(posedge clk) begin
      if (valid_out) begin
         last_reg <= lanes_out;
      end
   end
endmodule : fsc_far_end

// File: tb/four_wire_ternary_symbol_codec_test.sv
// Self-checking bench for the codec, transmit looped back through the far end.
// Assumes fsc_pkg, fsc_codec and fsc_far_end are compiled first.
`timescale 1ns/1ps
module four_wire_ternary_symbol_codec_test;
   import fsc_pkg::*;
   // Wire patterns for groups 0 to 7, {wire_three, wire_two, wire_one, wire_zero}
   localparam logic [11:0] PAT [8] = '{12'ha49, 12'heff, 12'hfdf, 12'h24d,
                                       12'hffb, 12'h269, 12'h349, 12'h7ff};
   logic clk = 1'b0, sys_rst = 1'b1, tx_valid = 1'b0, inj_valid = 1'b0;
   logic [2:0] tx_bits = 3'h0;
   logic [11:0] inj_lanes = 12'h000, out_lanes, in_lanes;
   logic out_valid, in_valid, rx_valid, rx_tie;
   logic [2:0] rx_bits;
   int fails = 0, checks_done = 0, cycles = 0;

   fsc_codec DUT (.clk(clk), .sys_rst(sys_rst), .tx_bits(tx_bits), .tx_valid(tx_valid),
      .serial_out_lanes(out_lanes), .tx_out_valid(out_valid), .serial_in_lanes(in_lanes),
      .rx_in_valid(in_valid), .rx_bits(rx_bits), .rx_valid(rx_valid), .rx_tie(rx_tie));
   fsc_far_end far (.clk(clk), .lanes_in(out_lanes), .valid_in(out_valid),
      .inj_lanes(inj_lanes), .inj_valid(inj_valid), .lanes_out(in_lanes),
      .valid_out(in_valid));

   // 50 ns clock; the ceiling cuts a hang short
   initial begin
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fails++;
         print_verdict();
      end
   end

   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         fails++;
      end
   endtask : chk

   task automatic print_verdict;
      if (fails == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : print_verdict

   // All eight groups back to back, then two idle cycles
   task automatic test_encode_all;
      logic [2:0] lvl;
      int s;
      logic ok;
      for (int k = 0; k < 11; k++) begin
         @(negedge clk);
         if (k >= 1 && k <= 8) begin
            chk("tx_lanes", PAT[k-1], out_lanes);
            chk("tx_out_valid", 12'h001, 12'(out_valid));
            s = 0;
            ok = 1'b1;
            for (int j = 0; j < 4; j++) begin
               lvl = out_lanes[j*3 +: 3];
               s += int'(signed'(lvl));
               if (!(lvl inside {3'h3, 3'h1, 3'h7, 3'h5})) ok = 1'b0;
            end
            chk("level_set", 12'h001, 12'(ok));
            chk("common_level", 12'h000, 12'(s));
         end
         if (k == 9) begin
            chk("idle_valid", 12'h000, 12'(out_valid));
            chk("idle_lanes", PAT[7], out_lanes);
         end
         if (k >= 2 && k <= 9) begin
            chk("rx_bits", 12'(k - 2), 12'(rx_bits));
            chk("rx_valid", 12'h001, 12'(rx_valid));
            chk("rx_tie", 12'h000, 12'(rx_tie));
         end
         if (k == 10) begin
            chk("rx_idle", 12'h000, 12'(rx_valid));
         end
         tx_bits = 3'(k);
         tx_valid = (k < 8);
      end
   endtask : test_encode_all

   // One injected symbol from the far end, decoded one cycle later
   task automatic send_rx(input logic [11:0] l, input logic [2:0] eb, input logic et);
      @(negedge clk);
      inj_lanes = l;
      inj_valid = 1'b1;
      @(negedge clk);
      inj_valid = 1'b0;
      chk("inj_rx_bits", 12'(eb), 12'(rx_bits));
      chk("inj_rx_tie", 12'(et), 12'(rx_tie));
      chk("inj_rx_valid", 12'h001, 12'(rx_valid));
   endtask : send_rx

   // Zero sums, a lone wire and a partial tie
   task automatic test_decode_edges;
      send_rx(12'h000, 3'h7, 1'b1);
      send_rx(12'h003, 3'h4, 1'b0);
      send_rx(12'h6c0, 3'h5, 1'b1);
      send_rx(12'hfff, 3'h5, 1'b1);
   endtask : test_decode_edges

   // Reset values, also when reset comes between edges
   task automatic test_reset;
      chk("rst_lanes", PAT[0], out_lanes);
      chk("rst_flags", 12'h000, {6'h00, out_valid, rx_valid, rx_tie, rx_bits});
   endtask : test_reset

   // A group sent on the first edge after a mid-run reset is released
   task automatic test_after_reset;
      @(negedge clk);
      sys_rst = 1'b0;
      tx_bits = 3'h5;
      tx_valid = 1'b1;
      @(negedge clk);
      tx_valid = 1'b0;
      chk("rel_lanes", PAT[5], out_lanes);
      chk("rel_valid", 12'h001, 12'(out_valid));
      @(negedge clk);
      chk("rel_rx_bits", 12'h005, 12'(rx_bits));
   endtask : test_after_reset

   initial begin
      repeat (20) @(negedge clk);
      test_reset();
      sys_rst = 1'b0;
      test_encode_all();
      test_decode_edges();
      @(negedge clk);
      sys_rst = 1'b1;
      #1;
      test_reset();
      chk("rst_rx_bits", 12'h000, 12'(rx_bits));
      test_after_reset();
      print_verdict();
   end
endmodule : four_wire_ternary_symbol_codec_test
